// file: rtl/xcvr_pkg.sv
package xcvr_pkg;

    // Bus word width on both data ports
    localparam int WORD_W = 8;

    // APB geometry
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;

    // Register byte offsets
    localparam logic [APB_ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [APB_ADDR_W-1:0] OFF_STORED = 12'h004;
    localparam logic [APB_ADDR_W-1:0] OFF_PINS = 12'h008;

    // Control register: write-one store strobes
    localparam int CTRL_STORE_A_BIT = 0;
    localparam int CTRL_STORE_B_BIT = 1;

    // Stored-word register layout
    localparam int STORED_A_LSB = 0;
    localparam int STORED_B_LSB = 8;

    // Pin status register layout
    localparam int PINS_A_LSB = 0;
    localparam int PINS_B_LSB = 8;
    localparam int PINS_A_OE_BIT = 16;
    localparam int PINS_B_OE_BIT = 17;

    // Reset values
    localparam logic [WORD_W-1:0] RESET_WORD = 8'h00;
    localparam logic [APB_DATA_W-1:0] RESET_RDATA = 32'h0000_0000;
    localparam logic STORE_CLOCK_RESET = 1'b1;

    // Data as driven onto a bus: complemented in the inverting build
    function automatic logic [WORD_W-1:0] pass_data(
        input logic invert,
        input logic [WORD_W-1:0] data
    );
        pass_data = invert ? ~data : data;
    endfunction

endpackage

// file: rtl/store_register.sv
`timescale 1ns/1ps

module store_register (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic store_clock,
    input wire logic sw_store,
    input wire logic [xcvr_pkg::WORD_W-1:0] capture_data,
    output logic [xcvr_pkg::WORD_W-1:0] word,
    output logic captured
);
    import xcvr_pkg::*;

    typedef struct packed {
        logic clock_q;
        logic [WORD_W-1:0] word;
    } state_t;

    state_t state;
    state_t next_state;
    logic rise;

    // Rising edge of the store clock, sampled on pclk
    assign rise = store_clock && !state.clock_q;
    assign captured = rise || sw_store;
    assign word = state.word;

    // Capture on a store edge or a software strobe, else hold
    always_comb begin
        next_state = state;
        next_state.clock_q = store_clock;
        if (captured) begin
            next_state.word = capture_data;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.clock_q <= STORE_CLOCK_RESET;
            state.word <= RESET_WORD;
        end else begin
            state <= next_state;
        end
    end

endmodule

// file: rtl/apb_slave.sv
`timescale 1ns/1ps

module apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xcvr_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [xcvr_pkg::APB_DATA_W-1:0] pwdata,
    output logic [xcvr_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [xcvr_pkg::WORD_W-1:0] stored_a,
    input wire logic [xcvr_pkg::WORD_W-1:0] stored_b,
    input wire logic [xcvr_pkg::WORD_W-1:0] pins_a,
    input wire logic [xcvr_pkg::WORD_W-1:0] pins_b,
    input wire logic a_oe,
    input wire logic b_oe,
    output logic store_a_pulse,
    output logic store_b_pulse
);
    import xcvr_pkg::*;

    typedef struct packed {
        logic [APB_DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic store_a;
        logic store_b;
    } state_t;

    state_t state;
    state_t next_state;
    logic [APB_DATA_W-1:0] read_word;

    // Known register offsets
    function automatic logic known(input logic [APB_ADDR_W-1:0] addr);
        known = (addr == OFF_CTRL) || (addr == OFF_STORED) ||
                (addr == OFF_PINS);
    endfunction

    // Read mux; strobes read back as zero
    always_comb begin
        read_word = RESET_RDATA;
        case (paddr)
            OFF_STORED: begin
                read_word[STORED_A_LSB +: WORD_W] = stored_a;
                read_word[STORED_B_LSB +: WORD_W] = stored_b;
            end
            OFF_PINS: begin
                read_word[PINS_A_LSB +: WORD_W] = pins_a;
                read_word[PINS_B_LSB +: WORD_W] = pins_b;
                read_word[PINS_A_OE_BIT] = a_oe;
                read_word[PINS_B_OE_BIT] = b_oe;
            end
            default: begin
                read_word = RESET_RDATA;
            end
        endcase
    end

    // One wait state, then answer; write acts at the completing edge
    always_comb begin
        next_state = state;
        next_state.pready = 1'b0;
        next_state.pslverr = 1'b0;
        next_state.prdata = RESET_RDATA;
        next_state.store_a = 1'b0;
        next_state.store_b = 1'b0;
        if (psel && penable && !state.pready) begin
            next_state.pready = 1'b1;
            next_state.pslverr = !known(paddr);
            if (!pwrite && known(paddr)) begin
                next_state.prdata = read_word;
            end
        end
        if (psel && penable && state.pready && pwrite &&
            (paddr == OFF_CTRL)) begin
            next_state.store_a = pwdata[CTRL_STORE_A_BIT];
            next_state.store_b = pwdata[CTRL_STORE_B_BIT];
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.prdata <= RESET_RDATA;
            state.pready <= 1'b0;
            state.pslverr <= 1'b0;
            state.store_a <= 1'b0;
            state.store_b <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata = state.prdata;
    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign store_a_pulse = state.store_a;
    assign store_b_pulse = state.store_b;

endmodule

// file: rtl/octal_registered_bus_transceiver.sv
`timescale 1ns/1ps

// How it works
// - Two eight-bit registers, one per direction
// - Store clock rising edge captures its bus
// - Both driving: each port still captured on its edge
// - Select low live data, high stored
// - B drives when high, A when low
// - B bus gets live or stored A
// - A bus gets live or stored B
// - Both stored words driven both ways
// - B driving alone: A into both registers
// - A driving alone: B into both registers
// - Both live and enabled: bus keeper
// - Inverting or true build-time variant
module octal_registered_bus_transceiver #(
    parameter bit INVERT = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [xcvr_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [xcvr_pkg::APB_DATA_W-1:0] pwdata,
    output logic [xcvr_pkg::APB_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [xcvr_pkg::WORD_W-1:0] a_in,
    output logic [xcvr_pkg::WORD_W-1:0] a_out,
    output logic a_oe,
    input wire logic [xcvr_pkg::WORD_W-1:0] b_in,
    output logic [xcvr_pkg::WORD_W-1:0] b_out,
    output logic b_oe,
    input wire logic a_store_clock,
    input wire logic b_store_clock,
    input wire logic a_drive_enable_n,
    input wire logic b_drive_enable,
    input wire logic a_source_select,
    input wire logic b_source_select
);
    import xcvr_pkg::*;

    typedef struct packed {
        logic [WORD_W-1:0] a_out;
        logic a_oe;
        logic [WORD_W-1:0] b_out;
        logic b_oe;
    } state_t;

    state_t state;
    state_t next_state;

    logic [WORD_W-1:0] a_word;
    logic [WORD_W-1:0] b_word;
    logic [WORD_W-1:0] a_capture;
    logic [WORD_W-1:0] b_capture;
    logic a_drive_on;
    logic b_drive_on;
    logic a_sw_store;
    logic b_sw_store;
    logic a_captured;
    logic b_captured;

    // Drive requests from the enable pins
    assign a_drive_on = !a_drive_enable_n;
    assign b_drive_on = b_drive_enable;

    // A lone driven bus carries the other side, so both load that side
    assign a_capture = (a_drive_on && !b_drive_on) ? b_in : a_in;
    assign b_capture = (b_drive_on && !a_drive_on) ? a_in : b_in;

    // Register fed from the A bus, drives the B path
    store_register u_a_reg (
        .pclk(pclk),
        .presetn(presetn),
        .store_clock(a_store_clock),
        .sw_store(a_sw_store),
        .capture_data(a_capture),
        .word(a_word),
        .captured(a_captured)
    );

    // Register fed from the B bus, drives the A path
    store_register u_b_reg (
        .pclk(pclk),
        .presetn(presetn),
        .store_clock(b_store_clock),
        .sw_store(b_sw_store),
        .capture_data(b_capture),
        .word(b_word),
        .captured(b_captured)
    );

    // Software view: store strobes, stored words, pin levels
    apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .stored_a(a_word),
        .stored_b(b_word),
        .pins_a(a_in),
        .pins_b(b_in),
        .a_oe(state.a_oe),
        .b_oe(state.b_oe),
        .store_a_pulse(a_sw_store),
        .store_b_pulse(b_sw_store)
    );

    // Output muxes; live paths loop back through pins as a keeper
    always_comb begin
        next_state = state;
        next_state.b_oe = b_drive_on;
        next_state.a_oe = a_drive_on;
        // Select picks live or stored source, variant sets polarity
        next_state.b_out = pass_data(INVERT,
            b_source_select ? a_word : a_in);
        next_state.a_out = pass_data(INVERT,
            a_source_select ? b_word : b_in);
    end

    // Pin driver registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state.a_out <= RESET_WORD;
            state.a_oe <= 1'b0;
            state.b_out <= RESET_WORD;
            state.b_oe <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    assign a_out = state.a_out;
    assign a_oe = state.a_oe;
    assign b_out = state.b_out;
    assign b_oe = state.b_oe;

    // Checks on the pin and register behaviour
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A edge with A bus an input stores the A pins
    property p_store_a;
        a_store_clock && !$past(a_store_clock) && $past(presetn) &&
        !(a_drive_on && !b_drive_on)
        |=> a_word == $past(a_in);
    endproperty
    a_store_a: assert property (p_store_a)
        else $error("A register missed an A store edge");

    // B edge with B bus an input stores the B pins
    property p_store_b;
        b_store_clock && !$past(b_store_clock) && $past(presetn) &&
        !(b_drive_on && !a_drive_on)
        |=> b_word == $past(b_in);
    endproperty
    a_store_b: assert property (p_store_b)
        else $error("B register missed a B store edge");

    // Both ports driving, an edge still samples the pins
    property p_store_while_driving;
        a_drive_on && b_drive_on && a_store_clock &&
        !$past(a_store_clock) && $past(presetn)
        |=> a_word == $past(a_in) && a_oe;
    endproperty
    a_store_while_driving: assert property (p_store_while_driving)
        else $error("A pins not stored while A port drives");

    // No edge and no strobe keeps both words
    property p_hold;
        !a_captured && !b_captured |=> $stable(a_word) && $stable(b_word);
    endproperty
    a_hold: assert property (p_hold)
        else $error("Stored word changed without a store");

    // B path live or stored, one cycle behind its source
    property p_b_path;
        b_drive_enable
        |=> b_oe && b_out == pass_data(INVERT, $past(b_source_select) ?
            $past(a_word) : $past(a_in));
    endproperty
    a_b_path: assert property (p_b_path)
        else $error("B bus not driven from the selected A source");

    // A path live or stored, one cycle behind its source
    property p_a_path;
        !a_drive_enable_n
        |=> a_oe && a_out == pass_data(INVERT, $past(a_source_select) ?
            $past(b_word) : $past(b_in));
    endproperty
    a_a_path: assert property (p_a_path)
        else $error("A bus not driven from the selected B source");

    // Isolation: neither port driven
    property p_isolation;
        !b_drive_enable && a_drive_enable_n |=> !a_oe && !b_oe;
    endproperty
    a_isolation: assert property (p_isolation)
        else $error("Port driven while isolated");

    // B port disabled for two cycles running is undriven in the next cycle
    property p_b_float;
        !b_drive_enable [*2] |=> !b_oe [*1];
    endproperty
    a_b_float: assert property (p_b_float)
        else $error("B port driven while disabled");

    // Both stored words out at once
    property p_both_stored;
        b_drive_enable && !a_drive_enable_n && a_source_select &&
        b_source_select
        |=> a_oe && b_oe && a_out == pass_data(INVERT, $past(b_word)) &&
            b_out == pass_data(INVERT, $past(a_word));
    endproperty
    a_both_stored: assert property (p_both_stored)
        else $error("Stored words not driven onto both buses");

    // B alone driving, both edges: A bus into both registers
    property p_b_alone_both;
        b_drive_on && !a_drive_on && $past(presetn) &&
        a_store_clock && !$past(a_store_clock) &&
        b_store_clock && !$past(b_store_clock)
        |=> a_word == $past(a_in) && b_word == $past(a_in);
    endproperty
    a_b_alone_both: assert property (p_b_alone_both)
        else $error("A data not stored in both registers");

    // A alone driving, both edges: B bus into both registers
    property p_a_alone_both;
        a_drive_on && !b_drive_on && $past(presetn) &&
        a_store_clock && !$past(a_store_clock) &&
        b_store_clock && !$past(b_store_clock)
        |=> a_word == $past(b_in) && b_word == $past(b_in);
    endproperty
    a_a_alone_both: assert property (p_a_alone_both)
        else $error("B data not stored in both registers");

    // A alone driving, only B edge: A register holds
    property p_a_alone_hold;
        a_drive_on && !b_drive_on && !a_captured && b_captured
        |=> $stable(a_word) && b_word == $past(b_in);
    endproperty
    a_a_alone_hold: assert property (p_a_alone_hold)
        else $error("A register changed on a B-only store");

    // Keeper: both live and enabled, each bus reinforced from the other
    property p_keeper;
        b_drive_enable && !a_drive_enable_n && !a_source_select &&
        !b_source_select
        |=> a_oe && b_oe && a_out == pass_data(INVERT, $past(b_in)) &&
            b_out == pass_data(INVERT, $past(a_in));
    endproperty
    a_keeper: assert property (p_keeper)
        else $error("Keeper loop not driving live data");

    // Polarity of the build variant on the live path
    property p_variant;
        b_drive_enable && !b_source_select
        |=> (b_out ^ $past(a_in)) == {WORD_W{INVERT}};
    endproperty
    a_variant: assert property (p_variant)
        else $error("Live data polarity does not match the variant");

    // Select low ignores the stored word
    property p_select_live;
        b_drive_enable && !b_source_select
        ##1 b_drive_enable && !b_source_select && $stable(a_in)
        |=> $stable(b_out);
    endproperty
    a_select_live: assert property (p_select_live)
        else $error("Live B output moved without A bus change");

    // Disabled A port stays undriven
    property p_a_float;
        a_drive_enable_n |=> !a_oe;
    endproperty
    a_a_float: assert property (p_a_float)
        else $error("A port driven while disabled");

    // B alone driving, only B store: A bus into B register, A holds
    property p_b_alone_b_edge;
        b_drive_on && !a_drive_on && !a_captured && b_captured
        |=> $stable(a_word) && b_word == $past(a_in);
    endproperty
    a_b_alone_b_edge: assert property (p_b_alone_b_edge)
        else $error("B register missed A data on a B-only store");

    // Isolation, both stores: each register takes its own bus
    property p_isolation_store;
        !b_drive_on && !a_drive_on && a_captured && b_captured
        |=> a_word == $past(a_in) && b_word == $past(b_in);
    endproperty
    a_isolation_store: assert property (p_isolation_store)
        else $error("Isolation store missed a bus");

    // Both ports driving, a B store still samples the B pins
    property p_store_b_while_driving;
        a_drive_on && b_drive_on && b_captured
        |=> b_word == $past(b_in);
    endproperty
    a_store_b_while_driving: assert property (p_store_b_while_driving)
        else $error("B pins not stored while B port drives");

endmodule

// file: verification/bus_side_model.sv
`timescale 1ns/1ps

module bus_side_model (
    input wire logic pclk,
    input wire logic [xcvr_pkg::WORD_W-1:0] a_out,
    input wire logic a_oe,
    input wire logic [xcvr_pkg::WORD_W-1:0] b_out,
    input wire logic b_oe,
    input wire logic ext_a_en,
    input wire logic [xcvr_pkg::WORD_W-1:0] ext_a_val,
    input wire logic ext_b_en,
    input wire logic [xcvr_pkg::WORD_W-1:0] ext_b_val,
    output logic [xcvr_pkg::WORD_W-1:0] a_in,
    output logic [xcvr_pkg::WORD_W-1:0] b_in
);
    import xcvr_pkg::*;
    logic [WORD_W-1:0] a_last = '0;
    logic [WORD_W-1:0] b_last = '0;

    // Last wire level, so an undriven line keeps changing
    always @(posedge pclk) begin
        a_last <= a_in;
        b_last <= b_in;
    end

    // Device driver first, then another source, else floating
    always_comb begin
        a_in = a_oe ? a_out : (ext_a_en ? ext_a_val : ~a_last);
        b_in = b_oe ? b_out : (ext_b_en ? ext_b_val : ~b_last);
    end
endmodule

// file: verification/octal_registered_bus_transceiver_tb_top.sv
`timescale 1ns/1ps

module octal_registered_bus_transceiver_tb_top;
    import xcvr_pkg::*;
    typedef struct packed {
        logic rd;
        logic [APB_DATA_W-1:0] data;
        logic err;
    } note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [APB_DATA_W-1:0] pwdata = '0, prdata;
    logic pready, pslverr, a_oe, b_oe, inv_a_oe, inv_b_oe;
    logic [WORD_W-1:0] a_in, b_in, a_out, b_out, inv_a_out, inv_b_out;
    logic a_store_clock = 1'b1, b_store_clock = 1'b1;
    logic a_drive_enable_n = 1'b1, b_drive_enable = 1'b0;
    logic a_source_select = 1'b0, b_source_select = 1'b0;
    logic ext_a_en = 1'b0, ext_b_en = 1'b0;
    logic [WORD_W-1:0] ext_a_val = '0, ext_b_val = '0, va, vb, wa, wb;
    int error_cnt = 0, checks = 0, seed = 32'h29C4BD67;
    note_t notes[$];

    always #4 pclk = ~pclk;

    octal_registered_bus_transceiver #(
        .INVERT(1'b0)
    ) i_octal_registered_bus_transceiver (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .a_in, .a_out, .a_oe, .b_in, .b_out,
        .b_oe, .a_store_clock, .b_store_clock, .a_drive_enable_n,
        .b_drive_enable, .a_source_select, .b_source_select);

    // Inverting build fed from the same wires
    octal_registered_bus_transceiver #(
        .INVERT(1'b1)
    ) i_octal_registered_bus_transceiver_inv (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata(), .pready(), .pslverr(), .a_in, .a_out(inv_a_out),
        .a_oe(inv_a_oe), .b_in, .b_out(inv_b_out), .b_oe(inv_b_oe),
        .a_store_clock, .b_store_clock, .a_drive_enable_n,
        .b_drive_enable, .a_source_select, .b_source_select);

    bus_side_model i_bus_side_model (
        .pclk, .a_out, .a_oe, .b_out, .b_oe, .ext_a_en, .ext_a_val,
        .ext_b_en, .ext_b_val, .a_in, .b_in);

    function automatic logic [WORD_W-1:0] rnd();
        return 8'($random(seed));
    endfunction

    task automatic fail(input logic [32:0] got, input logic [32:0] exp);
        error_cnt++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    endtask

    task automatic cmp_apb(input logic [31:0] d, input logic e,
                           input note_t x);
        checks++;
        if ({d, e} !== {x.data, x.err}) fail({d, e}, {x.data, x.err});
    endtask

    task automatic cmp_bus(input logic oe, input logic [7:0] o,
                           input logic eoe, input logic [7:0] eo);
        checks++;
        if ({oe, oe ? o : 8'h00} !== {eoe, eo}) fail({oe, o}, {eoe, eo});
    endtask

    task automatic conclude;
        error_cnt += notes.size();
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // One APB transfer; the expected answer is noted first
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] ad,
                       input logic [31:0] wd, input logic [31:0] ex,
                       input logic er);
        int n;
        notes.push_back('{!wr, ex, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Set controls and outside drivers, then let the pins settle
    task automatic drive(input logic an, bd, sla, slb, ea,
                         input logic [7:0] av, input logic eb,
                         input logic [7:0] bv);
        @(posedge pclk);
        a_drive_enable_n <= an;
        b_drive_enable <= bd;
        a_source_select <= sla;
        b_source_select <= slb;
        ext_a_en <= ea;
        ext_a_val <= av;
        ext_b_en <= eb;
        ext_b_val <= bv;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Rising edges on the chosen store clocks
    task automatic store(input logic ca, input logic cb);
        @(posedge pclk);
        a_store_clock <= !ca;
        b_store_clock <= !cb;
        @(posedge pclk);
        a_store_clock <= 1'b1;
        b_store_clock <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask

    // Answer monitor: oldest note against each completed transfer
    always @(posedge pclk) begin
        note_t x;
        if (presetn && pready === 1'b1) begin
            if (notes.size() == 0) begin
                fail(33'h0, 33'h1);
            end else begin
                x = notes.pop_front();
                cmp_apb(x.rd ? prdata : 32'h0, pslverr, x);
            end
        end
    end

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, OFF_STORED, 0, RESET_RDATA, 0);
        apb(0, OFF_CTRL, 0, 0, 0);
        apb(1, 12'h00C, 32'hFFFF_FFFF, 0, 1);
        apb(0, 12'h00C, 0, 0, 1);
        // Isolation: both ports listen and both store
        va = rnd();
        vb = rnd();
        drive(1, 0, 1, 1, 1, va, 1, vb);
        cmp_bus(a_oe, a_out, 0, 8'h00);
        cmp_bus(b_oe, b_out, 0, 8'h00);
        store(1, 1);
        wa = va;
        wb = vb;
        apb(1, OFF_STORED, 32'hFFFF_FFFF, 0, 0);
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        // B bus live, then stored
        va = rnd();
        drive(1, 1, 0, 0, 1, va, 0, 8'h00);
        cmp_bus(b_oe, b_out, 1, va);
        cmp_bus(inv_b_oe, inv_b_out, 1, ~va);
        cmp_bus(a_oe, a_out, 0, 8'h00);
        drive(1, 1, 0, 1, 1, va, 0, 8'h00);
        cmp_bus(b_oe, b_out, 1, wa);
        cmp_bus(inv_b_oe, inv_b_out, 1, ~wa);
        store(1, 1);
        wa = va;
        wb = va;
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        // A bus live, lone clock, both clocks, stored
        vb = rnd();
        drive(0, 0, 0, 0, 0, 8'h00, 1, vb);
        cmp_bus(a_oe, a_out, 1, vb);
        cmp_bus(inv_a_oe, inv_a_out, 1, ~vb);
        cmp_bus(b_oe, b_out, 0, 8'h00);
        store(0, 1);
        wb = vb;
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        store(1, 1);
        wa = vb;
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        drive(0, 0, 1, 0, 0, 8'h00, 1, ~vb);
        cmp_bus(a_oe, a_out, 1, wb);
        // Software strobe loads both words in isolation
        va = rnd();
        vb = ~va;
        drive(1, 0, 0, 0, 1, va, 1, vb);
        apb(1, OFF_CTRL, 32'h3, 0, 0);
        wa = va;
        wb = vb;
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        // Both ports send stored words, outside sources released
        drive(0, 1, 1, 1, 0, 8'h00, 0, 8'h00);
        cmp_bus(a_oe, a_out, 1, wb);
        cmp_bus(b_oe, b_out, 1, wa);
        // Pin view: A pins carry the B word, B pins the A word
        apb(0, OFF_PINS, 0, {14'h0, 2'h3, wa, wb}, 0);
        // Keeper: live both ways holds the last level
        va = rnd();
        drive(1, 1, 0, 0, 1, va, 0, 8'h00);
        drive(0, 1, 0, 0, 1, va, 0, 8'h00);
        drive(0, 1, 0, 0, 0, 8'h00, 0, 8'h00);
        cmp_bus(a_oe, a_out, 1, va);
        cmp_bus(b_oe, b_out, 1, va);
        // Both ports driving, stores still take the pins
        store(1, 1);
        wa = va;
        wb = va;
        apb(0, OFF_STORED, 0, {16'h0, wb, wa}, 0);
        cmp_bus(a_oe, a_out, 1, va);
        repeat (2) @(posedge pclk);
        conclude();
    end
endmodule
